// File: fcci_ctrl.sv
// Purpose: Coprocessor end of the host control and handshake interface.
// Assumes: Host clocks are sampled as synchronous edge enables of sys_clk_i.
// Notes: The arithmetic core lives elsewhere; it reports results on core ports.
`timescale 1ns/100ps
module fcci_ctrl
    import fcci_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Host clocks, one-cycle edge markers.
    input wire logic gated_clock_a_i,
    input wire logic gated_clock_b_i,
    input wire logic free_running_clock_i,
    // Host microcontrol strobes.
    input wire logic bus_transfer_inhibit_n_i,
    input wire logic coproc_select_i,
    input wire logic service_grant_strobe_i,
    input wire logic abort_strobe_i,
    input wire logic presence_query_strobe_i,
    input wire logic init_strobe_i,
    input wire logic error_abort_n_i,
    input wire logic coproc_present_enable_i,
    // Status and synchronisation from the host.
    input wire logic [STAT_W-1:0] float_status_reg_i,
    input wire logic sync_go_i,
    input wire logic instr_load_enable_n_i,
    input wire logic [DATA_W-1:0] instr_i,
    // Core result side.
    input wire logic [DATA_W-1:0] core_data_i,
    input wire logic core_overflow_i,
    input wire logic core_service_i,
    // Result bus toward the host.
    output logic [DATA_W-1:0] result_bus_to_cpu_o,
    output logic result_bus_to_cpu_oe_o,
    // Condition codes and handshake toward the host.
    output logic cc_load_enable_n_o,
    output logic cc_overflow_o,
    output logic cc_zero_o,
    output logic cc_negative_o,
    output logic sync_ack_o,
    output logic proceed_attention_o,
    output logic service_request_n_o,
    // Decode and mode view for the core.
    output logic [DATA_W-1:0] executing_instr_o,
    output logic exec_is_float_o,
    output logic mode_double_o,
    output logic mode_long_o,
    output logic busy_o
);
    logic [DATA_W-1:0] fetched_instr_reg;
    logic [DATA_W-1:0] executing_instr_reg;
    logic init_hit;
    logic abort_hit;
    logic grant_hit;
    logic query_hit;
    logic drive_hit;
    logic step;
    logic fetch_load;
    logic exec_load;
    fcci_state_e state;
    fcci_state_e next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic cc_v;
    logic cc_z;
    logic cc_n;
    logic next_cc_v;
    logic next_cc_z;
    logic next_cc_n;
    logic cc_en;
    logic next_cc_en;
    logic serv;
    logic next_serv;
    logic [DATA_W-1:0] out_data;
    logic [DATA_W-1:0] next_out_data;
    logic out_oe;
    logic next_out_oe;

    // Qualified host strobes.
    assign init_hit = (coproc_select_i && init_strobe_i)
        || !coproc_present_enable_i;
    assign abort_hit = (coproc_select_i && abort_strobe_i) || !error_abort_n_i;
    assign grant_hit = coproc_select_i && service_grant_strobe_i;
    assign drive_hit = coproc_select_i && bus_transfer_inhibit_n_i
        && coproc_present_enable_i;
    // An absent block stays silent, even to a presence query.
    assign query_hit = presence_query_strobe_i && drive_hit;
    // Synchronise and execute advance only on gated edges, so a frozen clock simply holds those states.
    assign step = gated_clock_a_i || gated_clock_b_i;
    assign fetch_load = free_running_clock_i && !instr_load_enable_n_i
        && coproc_present_enable_i;
    assign exec_load = (state == FCCI_SYNC) && step && !abort_hit;

    // Fetched-instruction register, loaded by the host.
    fcci_instr_reg u_fetched (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .clear_i(init_hit),
        .load_i(fetch_load),
        .data_i(instr_i),
        .data_o(fetched_instr_reg)
    );

    // Executing-instruction register, copied from the fetched one at start.
    fcci_instr_reg u_executing (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .clear_i(init_hit),
        .load_i(exec_load),
        .data_i(fetched_instr_reg),
        .data_o(executing_instr_reg)
    );

    // Sequencer: go, synchronise, execute, report, wait for next go.
    always_comb begin
        next_state = state;
        next_count = count;
        next_cc_v = cc_v;
        next_cc_z = cc_z;
        next_cc_n = cc_n;
        next_cc_en = 1'b0;
        next_serv = serv;
        if (init_hit || abort_hit) begin
            next_state = FCCI_IDLE;
            next_count = COUNT_ZERO;
            next_serv = 1'b0;
        end else begin
            if (grant_hit) begin
                next_serv = 1'b0;
            end
            unique case (state)
                FCCI_IDLE: begin
                    if (sync_go_i) begin
                        next_state = FCCI_SYNC;
                    end
                end
                FCCI_SYNC: begin
                    if (step) begin
                        next_state = FCCI_EXEC;
                        next_count = EXEC_CYCLES;
                    end
                end
                FCCI_EXEC: begin
                    if (step) begin
                        if (count == COUNT_ONE) begin
                            next_state = FCCI_DONE;
                            next_count = COUNT_ZERO;
                        end else begin
                            next_count = count - COUNT_ONE;
                        end
                    end
                end
                FCCI_DONE: begin
                    // Latch codes from the finished result and pulse the load enable.
                    next_cc_v = core_overflow_i;
                    next_cc_z = (core_data_i == DATA_ZERO);
                    next_cc_n = core_data_i[DATA_W-1];
                    next_cc_en = 1'b1;
                    if (core_service_i) begin
                        next_state = FCCI_SERV;
                        next_serv = 1'b1;
                    end else begin
                        next_state = FCCI_IDLE;
                    end
                end
                FCCI_SERV: begin
                    if (grant_hit) begin
                        next_state = FCCI_IDLE;
                    end
                end
                default: begin
                    next_state = FCCI_IDLE;
                end
            endcase
        end
    end

    // Sequencer and condition-code registers.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= FCCI_IDLE;
            count <= COUNT_ZERO;
            cc_v <= 1'b0;
            cc_z <= 1'b0;
            cc_n <= 1'b0;
            cc_en <= 1'b0;
            serv <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            cc_v <= next_cc_v;
            cc_z <= next_cc_z;
            cc_n <= next_cc_n;
            cc_en <= next_cc_en;
            serv <= next_serv;
        end
    end

    // Output mux onto the result bus, presence bit on a query.
    always_comb begin
        next_out_data = DATA_ZERO;
        next_out_oe = 1'b0;
        if (query_hit) begin
            next_out_data[PRESENCE_BIT] = 1'b1;
            next_out_oe = 1'b1;
        end else if (drive_hit) begin
            next_out_data = core_data_i;
            next_out_oe = 1'b1;
        end
    end

    // Result bus registers.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_data <= DATA_ZERO;
            out_oe <= 1'b0;
        end else begin
            out_data <= next_out_data;
            out_oe <= next_out_oe;
        end
    end

    // Host-facing outputs.
    assign result_bus_to_cpu_o = out_data;
    assign result_bus_to_cpu_oe_o = out_oe && bus_transfer_inhibit_n_i;
    assign cc_load_enable_n_o = !cc_en;
    assign cc_overflow_o = cc_v;
    assign cc_zero_o = cc_z;
    assign cc_negative_o = cc_n;
    assign sync_ack_o = (state == FCCI_EXEC) && (count == EXEC_CYCLES);
    assign proceed_attention_o = (state == FCCI_IDLE) && coproc_present_enable_i;
    assign service_request_n_o = !serv;
    // Decode view of the executing copy and live mode bits.
    assign executing_instr_o = executing_instr_reg;
    assign exec_is_float_o =
        (executing_instr_reg[FLOAT_OP_HI:FLOAT_OP_LO] == FLOAT_OP_CODE);
    assign mode_double_o = float_status_reg_i[MODE_DOUBLE_BIT];
    assign mode_long_o = float_status_reg_i[MODE_LONG_BIT];
    assign busy_o = (state != FCCI_IDLE);
endmodule

// File: fcci_ctrl_asserts.sv
// Purpose: Port checks of the coprocessor control interface.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound into every fcci_ctrl instance.
`timescale 1ns/100ps
module fcci_ctrl_asserts (
    // Clock, reset and host lines.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic gated_clock_a_i,
    input wire logic gated_clock_b_i,
    input wire logic bus_transfer_inhibit_n_i,
    input wire logic coproc_select_i,
    input wire logic service_grant_strobe_i,
    input wire logic abort_strobe_i,
    input wire logic presence_query_strobe_i,
    input wire logic init_strobe_i,
    input wire logic error_abort_n_i,
    input wire logic coproc_present_enable_i,
    // Coprocessor answers.
    input wire logic [15:0] result_bus_to_cpu_o,
    input wire logic result_bus_to_cpu_oe_o,
    input wire logic cc_load_enable_n_o,
    input wire logic sync_ack_o,
    input wire logic service_request_n_o,
    input wire logic busy_o
);
    // Events that clear the block, and a plain selection free of them.
    wire logic kill = coproc_select_i && (init_strobe_i || abort_strobe_i)
        || !error_abort_n_i || !coproc_present_enable_i;
    wire logic sel_plain = coproc_select_i && bus_transfer_inhibit_n_i && !kill;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_inhibit_no_drive: assert property (
        !bus_transfer_inhibit_n_i |-> !result_bus_to_cpu_oe_o)
        else $error("Bus driven under inhibit.");
    a_select_drives_bus: assert property (
        sel_plain ##1 bus_transfer_inhibit_n_i |-> result_bus_to_cpu_oe_o)
        else $error("Selected bus not driven.");
    a_presence_bit_set: assert property (
        sel_plain && presence_query_strobe_i ##1 bus_transfer_inhibit_n_i
        |-> result_bus_to_cpu_oe_o && result_bus_to_cpu_o[14])
        else $error("Presence bit missing.");
    a_cc_one_cycle: assert property ($fell(cc_load_enable_n_o) |=> cc_load_enable_n_o)
        else $error("Code load enable too long.");
    a_ack_after_edge: assert property (
        $rose(sync_ack_o) |-> $past(gated_clock_a_i || gated_clock_b_i))
        else $error("Ack without gated edge.");
    a_init_clears: assert property (
        coproc_select_i && init_strobe_i |=> !busy_o && !sync_ack_o && service_request_n_o)
        else $error("Init did not clear.");
    a_abort_drops: assert property (
        coproc_select_i && abort_strobe_i || !error_abort_n_i |=> !busy_o && service_request_n_o)
        else $error("Abort did not drop.");
    a_absent_quiet: assert property (
        !coproc_present_enable_i |=> !busy_o && !result_bus_to_cpu_oe_o)
        else $error("Absent block active.");
    a_service_held: assert property (
        $rose(service_request_n_o) |-> $past(kill || coproc_select_i && service_grant_strobe_i))
        else $error("Service dropped ungranted.");
endmodule
bind fcci_ctrl fcci_ctrl_asserts fcci_ctrl_asserts_inst (.*);

// File: fcci_host_model.sv
// Purpose: Host side model giving clocks, go and instructions.
// Assumes: Strobes and core inputs come from the bench.
// Notes: Port names follow the coprocessor nets they meet.
`timescale 1ns/100ps
module fcci_host_model (
    // Clock and coprocessor answers.
    input wire logic sys_clk_i,
    input wire logic proceed_attention_o,
    input wire logic cc_load_enable_n_o,
    // Host clocks, go and instruction.
    output logic gated_clock_a_i,
    output logic gated_clock_b_i,
    output logic free_running_clock_i,
    output logic sync_go_i,
    output logic instr_load_enable_n_i,
    output logic [15:0] instr_i
);
    // The free clock marker never stalls; gated markers only come from tasks.
    initial begin
        {gated_clock_a_i, gated_clock_b_i, sync_go_i, free_running_clock_i} = 4'h0;
        instr_load_enable_n_i = 1'b1;
        instr_i = 16'hA5A5;
        forever begin
            @(posedge sys_clk_i) #2;
            free_running_clock_i = !free_running_clock_i;
        end
    end
    // Two enabled cycles catch one free marker; the released line then inverts.
    task automatic load(input logic [15:0] w);
        @(posedge sys_clk_i) #2;
        instr_i = w;
        instr_load_enable_n_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #2;
        instr_load_enable_n_i = 1'b1;
        instr_i = ~w;
    endtask
    // One gated edge marker, then a stall of gap plus one cycles with no edges.
    task automatic mark(input logic b, input int gap);
        gated_clock_a_i = !b;
        gated_clock_b_i = b;
        @(posedge sys_clk_i) #2;
        {gated_clock_a_i, gated_clock_b_i} = 2'h0;
        repeat (gap + 1) @(posedge sys_clk_i);
        #2;
    endtask
    // Waits for attention, raises go for a cycle, then gives the synchronising edge.
    task automatic start();
        int n = 0;
        while (proceed_attention_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk_i) #2;
            n++;
        end
        sync_go_i = 1'b1;
        @(posedge sys_clk_i) #2;
        sync_go_i = 1'b0;
        mark(1'b0, 0);
    endtask
    // Four more edges end the operation. The last one comes with no stall after it,
    // since the code load pulse stands one cycle only and a long wait would miss it.
    task automatic finish(input int gap);
        int n = 0;
        for (int i = 0; i < 3; i++) mark(i[0], gap);
        gated_clock_b_i = 1'b1;
        @(posedge sys_clk_i) #2;
        gated_clock_b_i = 1'b0;
        while (cc_load_enable_n_o !== 1'b0 && n < 20) begin
            @(posedge sys_clk_i) #2;
            n++;
        end
    endtask
endmodule

// File: fcci_instr_reg.sv
// Purpose: Enabled 16-bit instruction holding register.
// Assumes: Load is a synchronous enable on the system clock.
// Notes: Clears to a neutral value on reset or synchronous clear.
`timescale 1ns/100ps
module fcci_instr_reg
    import fcci_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Control.
    input wire logic clear_i,
    input wire logic load_i,
    // Data.
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] next_value;

    // Clear has priority over load.
    always_comb begin
        next_value = value;
        if (clear_i) begin
            next_value = INSTR_RESET;
        end else if (load_i) begin
            next_value = data_i;
        end
    end

    // Holds the value.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value <= INSTR_RESET;
        end else begin
            value <= next_value;
        end
    end

    assign data_o = value;
endmodule

// File: fcci_pkg.sv
// Purpose: Constants and types shared by the coprocessor control interface.
// Assumes: One 50 MHz system clock; gated host clocks arrive as synchronous enables.
// Notes: The host microcode drives every strobe; this side only reacts.
// How it works
// - Gated clocks may stall; logic tolerates it.
// - Inhibit low keeps result bus undriven.
// - Select without inhibit drives output data.
// - Service counts granted on grant plus select.
// - Abort strobe with select drops instruction.
// - Presence query drives result bit 14 high.
// - Init strobe with select initialises coprocessor.
// - Status bits three and two set modes.
// - Condition-code load enable low only when loading.
// - Overflow, zero, negative codes from last result.
// - Acknowledge once synchronised with the host.
// - Attention marks ready to proceed.
// - Operate only while present enable high.
// - Fetched register loads only when enabled.
// - Error abort line drops current instruction.
// - Copy fetched to executing register, decode it.
package fcci_pkg;
    localparam int DATA_W = 16;
    localparam int STAT_W = 4;
    localparam int PRESENCE_BIT = 14;
    localparam int FLOAT_OP_HI = 15;
    localparam int FLOAT_OP_LO = 12;
    localparam logic [3:0] FLOAT_OP_CODE = 4'hF;
    localparam int MODE_DOUBLE_BIT = 3;
    localparam int MODE_LONG_BIT = 2;
    localparam logic [DATA_W-1:0] INSTR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    // Execution cycles counted on gated clock edges; short fixed figure.
    localparam logic [3:0] EXEC_CYCLES = 4'h4;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONE = 4'h1;

    typedef enum logic [2:0] {
        FCCI_IDLE = 3'b000,
        FCCI_SYNC = 3'b001,
        FCCI_EXEC = 3'b010,
        FCCI_DONE = 3'b011,
        FCCI_SERV = 3'b100
    } fcci_state_e;
endpackage

// File: test_fcci_ctrl.sv
// Purpose: Self-checking bench of the coprocessor control interface.
// Assumes: Host model gives clocks and words; bench drives strobes and core.
// Notes: Random words come from a shift register seeded at 82.
`timescale 1ns/100ps
module test_fcci_ctrl
    import fcci_pkg::*;
;
    logic sys_clk_i, nrst_i, gated_clock_a_i, gated_clock_b_i, free_running_clock_i;
    logic bus_transfer_inhibit_n_i, coproc_select_i, service_grant_strobe_i, abort_strobe_i;
    logic presence_query_strobe_i, init_strobe_i, error_abort_n_i, coproc_present_enable_i;
    logic sync_go_i, instr_load_enable_n_i, core_overflow_i, core_service_i, busy_o;
    logic [STAT_W-1:0] float_status_reg_i;
    logic [DATA_W-1:0] instr_i, core_data_i, result_bus_to_cpu_o, executing_instr_o, seed, w, prev;
    logic result_bus_to_cpu_oe_o, cc_load_enable_n_o, cc_overflow_o, cc_zero_o, cc_negative_o;
    logic sync_ack_o, proceed_attention_o, service_request_n_o;
    logic exec_is_float_o, mode_double_o, mode_long_o;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    fcci_ctrl fcci_ctrl_inst (.*);
    fcci_host_model fcci_host_model_inst (.*);
    // Clock and hang guard.
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = !sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            test_done();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic tick();
        @(posedge sys_clk_i) #2;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One clearing event for a cycle: abort, error abort, init, absent.
    task automatic kill(input int k);
        coproc_select_i = (k == 0 || k == 2);
        abort_strobe_i = (k == 0);
        error_abort_n_i = (k != 1);
        init_strobe_i = (k == 2);
        coproc_present_enable_i = (k != 3);
        tick();
        {coproc_select_i, abort_strobe_i, init_strobe_i} = 3'h0;
        {error_abort_n_i, coproc_present_enable_i} = 2'h3;
    endtask
    // Main sequence.
    initial begin
        nrst_i = 1'b0;
        {coproc_select_i, service_grant_strobe_i, abort_strobe_i, init_strobe_i} = 4'h0;
        {presence_query_strobe_i, core_overflow_i, core_service_i} = 3'h0;
        {bus_transfer_inhibit_n_i, error_abort_n_i, coproc_present_enable_i} = 3'h7;
        float_status_reg_i = 4'h0;
        core_data_i = 16'h0000;
        seed = 16'h0052;
        prev = INSTR_RESET;
        repeat (6) @(posedge sys_clk_i);
        #2;
        nrst_i = 1'b1;
        tick();
        check({service_request_n_o, sync_ack_o, cc_load_enable_n_o}, 16'h0005);
        check(proceed_attention_o, 1'b1);
        coproc_select_i = 1'b1;
        presence_query_strobe_i = 1'b1;
        tick();
        presence_query_strobe_i = 1'b0;
        check(result_bus_to_cpu_o[PRESENCE_BIT], 1'b1);
        check(result_bus_to_cpu_oe_o, 1'b1);
        // Inhibit stays off one more edge, then falls while the bus is driven.
        tick();
        bus_transfer_inhibit_n_i = 1'b0;
        #1 check(result_bus_to_cpu_oe_o, 1'b0);
        tick();
        {bus_transfer_inhibit_n_i, coproc_select_i} = 2'h2;
        // A plain selection routes a random core word onto the bus.
        seed = lfsr(seed);
        {coproc_select_i, core_data_i} = {1'b1, seed};
        tick();
        check(result_bus_to_cpu_o, seed);
        coproc_select_i = 1'b0;
        for (int i = 0; i < 16; i++) begin
            float_status_reg_i = i[3:0];
            #1 check({mode_double_o, mode_long_o}, i[3:2]);
            tick();
        end
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            w = {(i == 3) ? 4'h7 : FLOAT_OP_CODE, seed[11:0]};
            fcci_host_model_inst.load(w);
            check(executing_instr_o, prev);
            seed = lfsr(seed);
            core_data_i = (i == 0) ? 16'h0000 : (i == 1) ? (seed | 16'h8000) : seed;
            {core_overflow_i, core_service_i, float_status_reg_i} = {seed[3], i == 4, seed[7:4]};
            fcci_host_model_inst.start();
            check(sync_ack_o, 1'b1);
            check(executing_instr_o, w);
            check(exec_is_float_o, i != 3);
            fcci_host_model_inst.finish(i);
            check(cc_load_enable_n_o, 1'b0);
            check({cc_zero_o, cc_negative_o},
                {core_data_i == 16'h0000, core_data_i[15]});
            check(cc_overflow_o, core_overflow_i);
            prev = w;
        end
        core_service_i = 1'b0;
        check(service_request_n_o, 1'b0);
        service_grant_strobe_i = 1'b1;
        tick();
        check(service_request_n_o, 1'b0);
        coproc_select_i = 1'b1;
        tick();
        {coproc_select_i, service_grant_strobe_i} = 2'h0;
        check(service_request_n_o, 1'b1);
        for (int k = 0; k < 4; k++) begin
            fcci_host_model_inst.start();
            check(busy_o, 1'b1);
            kill(k);
            check({busy_o, sync_ack_o}, 16'h0000);
        end
        test_done();
    end
endmodule
